// ### logic/dttc_top.sv
// dttc_top: digital control of a dual-tone transceiver with call progress detection
// assumes analog band detectors deliver levels on pins and an APB master on pclk
//
// Notes on behaviour
// RULE1 - digit and valid shown after tone, cleared after pause
// RULE2 - generator uses receiver's hex digit encoding
// RULE3 - falling load strobe captures code, starts tones
// RULE4 - reset disables tones until next capture
// RULE5 - accept tone 40 ms, reject 20 ms
// RULE6 - gap 40 ms ends digit, 20 ms bridged
// RULE7 - progress energy 40 ms reported, 10 ms ignored
// RULE8 - progress absence 40 ms reported, 20 ms bridged
// RULE9 - cadence output follows qualified energy pattern
// RULE10 - strobe and reset may share one wire
// RULE11 - all timing derived from one time base
// RULE12 - receive code driven only while enable low
// RULE13 - zero A, star B, pound C, D zero
// RULE14 - pins synchronised, durations counted in ticks; output_enable_n gates rx_code_oe without a synchroniser
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module dttc_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receiver front end: tone present and decoded hex digit code
    input wire logic tone_present_in,
    input wire logic [3:0] tone_code_in,
    // receiver outputs
    input wire logic output_enable_n,
    output logic [3:0] rx_code,
    output logic [3:0] rx_code_oe,
    output logic digit_valid,
    // generator
    input wire logic [3:0] tx_code,
    input wire logic tone_load_strobe,
    input wire logic gen_reset,
    output logic [1:0] tone_out,
    output logic tone_active,
    // call progress
    input wire logic progress_line_in,
    output logic cadence_detect_out,
    // interrupt
    output logic irq
);
    // ---------- pin synchronisers, three stages ----------
    logic [2:0] s_tone, s_strobe, s_reset, s_cp;
    logic [3:0] s_code1, s_code2, s_code3, s_tx1, s_tx2, s_tx3, code_q, tx_q;
    logic strobe_q, reset_q, tone_q, cp_q;

    // stage 3 pairs with stage 2; a change counts once both agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_tone <= 3'h0;
            s_strobe <= 3'h0;
            s_reset <= 3'h0;
            s_cp <= 3'h0;
            s_code1 <= 4'h0;
            s_code2 <= 4'h0;
            s_tx1 <= 4'h0;
            s_tx2 <= 4'h0;
            s_code3 <= 4'h0;
            s_tx3 <= 4'h0;
        end else begin
            s_tone <= {s_tone[1:0], tone_present_in}; // RULE14
            s_strobe <= {s_strobe[1:0], tone_load_strobe}; // RULE14
            s_reset <= {s_reset[1:0], gen_reset}; // RULE14
            s_cp <= {s_cp[1:0], progress_line_in};
            s_code1 <= tone_code_in;
            s_code2 <= s_code1;
            s_tx1 <= tx_code;
            s_tx2 <= s_tx1;
            s_code3 <= s_code2; // RULE14
            s_tx3 <= s_tx2; // RULE14
        end
    end

    // filtered levels update only when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_q <= 1'b0;
            reset_q <= 1'b0;
            tone_q <= 1'b0;
            cp_q <= 1'b0;
            code_q <= 4'h0;
            tx_q <= 4'h0;
        end else begin
            if (s_strobe[2] == s_strobe[1]) strobe_q <= s_strobe[2];
            if (s_reset[2] == s_reset[1]) reset_q <= s_reset[2];
            if (s_tone[2] == s_tone[1]) tone_q <= s_tone[2];
            if (s_cp[2] == s_cp[1]) cp_q <= s_cp[2];
            if (s_code3 == s_code2) code_q <= s_code3; // a word moves only once all bits settle
            if (s_tx3 == s_tx2) tx_q <= s_tx3;
        end
    end

    // ---------- 1 ms tick divider ----------
    logic [13:0] div_cnt;
    wire tick = div_cnt == 14'(dttc_pkg::TICK_CYC - 1);

    // every duration is counted in ticks of this one time base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_cnt <= 14'h0000;
        else if (tick) div_cnt <= 14'h0000; // RULE11
        else div_cnt <= div_cnt + 14'h0001;
    end

    // ticks for which a level has held, saturating; the duration checks use it
    function automatic logic [7:0] dttc_run(input logic [7:0] run, input logic level, input logic tk);
        if (!level) return 8'h00;
        if (tk && run != 8'hFF) return run + 8'h01;
        return run;
    endfunction

    // run lengths kept apart from the qualifiers, so a broken threshold shows up
    logic [7:0] tone_hi_run, tone_lo_run, cp_hi_run, cp_lo_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_hi_run <= 8'h00;
            tone_lo_run <= 8'h00;
            cp_hi_run <= 8'h00;
            cp_lo_run <= 8'h00;
        end else begin
            tone_hi_run <= dttc_run(tone_hi_run, tone_q, tick);
            tone_lo_run <= dttc_run(tone_lo_run, !tone_q, tick);
            cp_hi_run <= dttc_run(cp_hi_run, cp_q, tick);
            cp_lo_run <= dttc_run(cp_lo_run, !cp_q, tick);
        end
    end

    // ---------- receiver qualification ----------
    logic tone_qual, cp_qual;

    // tone: 30 ms to accept (RULE5), 30 ms of gap to release (RULE6)
    dttc_qual u_tone_qual (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .on_ticks(dttc_pkg::TONE_QUAL_TICKS),
        .off_ticks(dttc_pkg::GAP_QUAL_TICKS),
        .raw(tone_q),
        .qualified(tone_qual)
    );

    // band energy: 25 ms to report on (RULE7), 30 ms to report off (RULE8)
    dttc_qual u_cp_qual (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .on_ticks(dttc_pkg::CP_ON_TICKS),
        .off_ticks(dttc_pkg::CP_OFF_TICKS),
        .raw(cp_q),
        .qualified(cp_qual)
    );

    logic tone_qual_d, cp_qual_d;
    wire digit_rise = tone_qual && !tone_qual_d;
    wire cp_rise = cp_qual && !cp_qual_d;
    wire cp_fall = !cp_qual && cp_qual_d;

    // digit code latched at detection, cleared with valid after the pause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_qual_d <= 1'b0;
            cp_qual_d <= 1'b0;
            rx_code <= 4'h0;
            digit_valid <= 1'b0;
            cadence_detect_out <= 1'b0;
        end else begin
            tone_qual_d <= tone_qual;
            cp_qual_d <= cp_qual;
            cadence_detect_out <= cp_qual; // RULE9
            digit_valid <= tone_qual; // RULE1
            if (digit_rise) rx_code <= code_q; // RULE1 RULE13
            else if (!tone_qual) rx_code <= 4'h0; // RULE1
        end
    end

    // ---------- receive output enable ----------
    logic [31:0] ctrl;
    wire oe_active = !output_enable_n && !ctrl[dttc_pkg::CTRL_OE_N];
    // three-state pins: the pad ring drives only while enabled
    assign rx_code_oe = {4{oe_active}}; // RULE12

    // ---------- generator ----------
    logic strobe_qd;
    logic [3:0] gen_code;
    wire strobe_fall = strobe_qd && !strobe_q;

    // row and column index of each hex code; 0 is D, A is zero
    function automatic logic [3:0] dttc_rowcol(input logic [3:0] code);
        unique case (code)
            4'h1: dttc_rowcol = 4'h0;
            4'h2: dttc_rowcol = 4'h1;
            4'h3: dttc_rowcol = 4'h2;
            4'h4: dttc_rowcol = 4'h4;
            4'h5: dttc_rowcol = 4'h5;
            4'h6: dttc_rowcol = 4'h6;
            4'h7: dttc_rowcol = 4'h8;
            4'h8: dttc_rowcol = 4'h9;
            4'h9: dttc_rowcol = 4'hA;
            dttc_pkg::CODE_ZERO: dttc_rowcol = 4'hD;
            dttc_pkg::CODE_STAR: dttc_rowcol = 4'hC;
            dttc_pkg::CODE_POUND: dttc_rowcol = 4'hE;
            4'hD: dttc_rowcol = 4'h3;
            4'hE: dttc_rowcol = 4'h7;
            4'hF: dttc_rowcol = 4'hB;
            dttc_pkg::CODE_D: dttc_rowcol = 4'hF;
        endcase
    endfunction

    // phase step for 2^24 * f / 10 MHz
    function automatic logic [23:0] dttc_step(input logic [1:0] idx, input logic high);
        logic [23:0] s;
        s = 24'h000000;
        unique case ({high, idx})
            3'b000: s = 24'h000492; // 697 Hz
            3'b001: s = 24'h000509; // 770 Hz
            3'b010: s = 24'h00058F; // 852 Hz
            3'b011: s = 24'h000627; // 941 Hz
            3'b100: s = 24'h0007EC; // 1209 Hz
            3'b101: s = 24'h0008C2; // 1336 Hz
            3'b110: s = 24'h0009AE; // 1477 Hz
            3'b111: s = 24'h000AB3; // 1633 Hz
        endcase
        return s;
    endfunction

    // strobe and reset may fall together: the reset stops tones, the fall reloads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_qd <= 1'b0;
            gen_code <= 4'h0;
            tone_active <= 1'b0;
        end else begin
            strobe_qd <= strobe_q;
            if (strobe_fall) begin
                gen_code <= tx_q; // RULE2 RULE3
                tone_active <= 1'b1; // RULE3 RULE10
            end else if (reset_q) begin
                tone_active <= 1'b0; // RULE4
            end
        end
    end

    // two phase accumulators; the msb of each is a square-wave tone
    logic [23:0] ph_lo, ph_hi;
    wire [3:0] rc = dttc_rowcol(gen_code);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_lo <= 24'h000000;
            ph_hi <= 24'h000000;
            tone_out <= 2'b00;
        end else if (!tone_active) begin
            ph_lo <= 24'h000000; // RULE4
            ph_hi <= 24'h000000;
            tone_out <= 2'b00;
        end else begin
            ph_lo <= ph_lo + dttc_step(rc[3:2], 1'b0); // RULE3
            ph_hi <= ph_hi + dttc_step(rc[1:0], 1'b1);
            tone_out <= {ph_hi[23], ph_lo[23]};
        end
    end

    // ---------- apb registers and interrupts ----------
    localparam int IRQ_W_L = dttc_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] int_stat, int_mask;
    wire wr = psel && penable && pwrite;
    wire [IRQ_W_L-1:0] events = {cp_fall, cp_rise, digit_rise};
    wire hit_ctrl = paddr == dttc_pkg::REG_CTRL;
    wire hit_stat = paddr == dttc_pkg::REG_STATUS;
    wire hit_int = paddr == dttc_pkg::REG_INT_STAT;
    wire hit_mask = paddr == dttc_pkg::REG_INT_MASK;
    wire mapped = hit_ctrl || hit_stat || hit_int || hit_mask;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq = |(int_stat & int_mask);

    // status bits: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= dttc_pkg::CTRL_RESET;
            int_stat <= '0;
            int_mask <= '0;
        end else begin
            if (wr && hit_ctrl) ctrl <= {31'h0, pwdata[0]};
            if (wr && hit_mask) int_mask <= pwdata[IRQ_W_L-1:0];
            int_stat <= (int_stat & ~((wr && hit_int) ? pwdata[IRQ_W_L-1:0] : '0)) | events;
        end
    end

    // read data registered at the setup cycle, valid in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0000_0000;
        else if (psel && !penable) begin
            prdata <= hit_ctrl ? ctrl :
                      hit_stat ? {24'h0, tone_active, cadence_detect_out, digit_valid, 1'b0, rx_code} :
                      hit_int ? {29'h0, int_stat} :
                      hit_mask ? {29'h0, int_mask} : 32'h0000_0000;
        end
    end

    // ---------- assertions ----------
    a_valid_code_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        !digit_valid |-> rx_code == 4'h0) else $error("code not cleared without valid");
    a_valid_after_qual: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        digit_rise |=> digit_valid) else $error("valid missing after detection");
    a_strobe_loads: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        strobe_fall |=> tone_active && gen_code == $past(tx_q)) else $error("strobe did not load");
    a_reset_silences: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        reset_q && !strobe_fall |=> !tone_active) else $error("tones not stopped by reset");
    a_off_no_tone: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        !tone_active |=> tone_out == 2'b00) else $error("tone out while disabled");
    a_oe_follows_pin: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        output_enable_n |-> rx_code_oe == 4'h0) else $error("driven while disabled");
    a_cadence_follow: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        $rose(cp_qual) |=> cadence_detect_out) else $error("cadence not following");
    a_short_burst: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        $rose(cp_qual) |-> cp_hi_run > 8'(dttc_pkg::CP_ON_REJECT_MS)) else $error("cadence rose on a short burst");
    a_tick_period: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        tick |=> !tick) else $error("tick longer than a cycle");
    // duration checks: every qualified change must outlast its reject limit
    a_tone_min_len: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        $rose(tone_qual) |-> tone_hi_run > 8'(dttc_pkg::TONE_REJECT_MS)) else $error("short tone accepted");
    a_gap_bridge: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        $fell(tone_qual) |-> tone_lo_run > 8'(dttc_pkg::GAP_BRIDGE_MS)) else $error("short gap ended digit");
    a_cp_off_len: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        $fell(cp_qual) |-> cp_lo_run > 8'(dttc_pkg::CP_OFF_BRIDGE_MS)) else $error("short absence reported");
    // the generator only starts from a captured code
    a_tone_needs_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        $rose(tone_active) |-> $past(strobe_fall)) else $error("tones started without a load");
    a_cadence_release: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        $fell(cp_qual) |=> !cadence_detect_out) else $error("cadence not released");
    a_code_steady: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        digit_valid && $past(digit_valid) |-> $stable(rx_code)) else $error("code changed while valid");
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        digit_rise |=> int_stat[dttc_pkg::IRQ_DIGIT]) else $error("digit event lost");
endmodule

// ### logic/dttc_pkg.sv
// dttc_pkg: constants shared by the dual-tone transceiver control logic
// assumes a 10 MHz pclk and an APB master on the register side
package dttc_pkg;
    // clock and timing
    localparam int CLK_HZ = 10000000;
    localparam int MS_TO_CYC = CLK_HZ / 1000;
    localparam int TONE_ON_MIN_MS = 40;
    localparam int TONE_REJECT_MS = 20;
    localparam int GAP_END_MS = 40;
    localparam int GAP_BRIDGE_MS = 20;
    localparam int CP_ON_MIN_MS = 40;
    localparam int CP_ON_REJECT_MS = 10;
    localparam int CP_OFF_MIN_MS = 40;
    localparam int CP_OFF_BRIDGE_MS = 20;
    // qualification tick: 1 ms from the divider
    localparam int TICK_CYC = MS_TO_CYC;
    // qualify at the midpoint between the reject and accept limits, in ticks
    localparam logic [7:0] TONE_QUAL_TICKS = 8'(((TONE_ON_MIN_MS + TONE_REJECT_MS) / 2));
    localparam logic [7:0] GAP_QUAL_TICKS = 8'(((GAP_END_MS + GAP_BRIDGE_MS) / 2));
    localparam logic [7:0] CP_ON_TICKS = 8'(((CP_ON_MIN_MS + CP_ON_REJECT_MS) / 2));
    localparam logic [7:0] CP_OFF_TICKS = 8'(((CP_OFF_MIN_MS + CP_OFF_BRIDGE_MS) / 2));
    // tone synthesis: phase step per pclk = f * 2^24 / CLK_HZ
    localparam int PHASE_W = 24;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0C;
    // ctrl fields
    localparam int CTRL_OE_N = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // interrupt bits
    localparam int IRQ_DIGIT = 0;
    localparam int IRQ_CP_ON = 1;
    localparam int IRQ_CP_OFF = 2;
    localparam int IRQ_W = 3;
    // digit encodings
    localparam logic [3:0] CODE_ZERO = 4'hA;
    localparam logic [3:0] CODE_STAR = 4'hB;
    localparam logic [3:0] CODE_POUND = 4'hC;
    localparam logic [3:0] CODE_D = 4'h0;
endpackage

// ### logic/dttc_qual.sv
// dttc_qual: debounces a level by requiring it to hold for a count of ticks
// assumes the input is already synchronous to pclk
`timescale 1ns/1ns
module dttc_qual (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // timing
    input wire logic tick,
    input wire logic [7:0] on_ticks,
    input wire logic [7:0] off_ticks,
    // level in and qualified level out
    input wire logic raw,
    output logic qualified
);
    logic [7:0] cnt;
    wire differs = raw != qualified;
    wire [7:0] limit = qualified ? off_ticks : on_ticks;

    // a level that differs restarts whenever it flips back, so short bursts never win
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            qualified <= 1'b0;
        end else if (!differs) begin
            cnt <= 8'h00;
        end else if (tick) begin
            if (cnt + 8'h01 >= limit) begin
                qualified <= raw;
                cnt <= 8'h00;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// ### tb/dttc_host.sv
// dttc_host: processor side that loads dial codes and watches the digit bus
// assumes the bench calls its tasks from a thread that runs on pclk
`timescale 1ns/1ns
module dttc_host (
    // clock
    input wire logic pclk,
    // digit bus from the device
    input wire logic [3:0] rx_code,
    input wire logic [3:0] rx_code_oe,
    output logic [3:0] rx_bus,
    // dialling side
    output logic [3:0] tx_code,
    output logic tone_load_strobe,
    output logic gen_reset
);
    logic [3:0] last = 4'h0;
    initial begin
        tx_code = 4'h0;
        tone_load_strobe = 1'b0;
        gen_reset = 1'b0;
    end
    // no pull-up on the bus, so a released bit wanders rather than keep its value
    always_comb begin
        for (int i = 0; i < 4; i++) rx_bus[i] = rx_code_oe[i] ? rx_code[i] : ~last[i];
    end
    always_ff @(posedge pclk) last <= rx_bus;
    // strobe pulse; tied also raises reset with it, as one shared wire would
    task automatic load(input logic [3:0] c, input logic tied);
        @(posedge pclk);
        tx_code <= c;
        tone_load_strobe <= 1'b1;
        gen_reset <= tied;
        repeat (6) @(posedge pclk);
        tone_load_strobe <= 1'b0;
        gen_reset <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    // reset pulse alone, long enough for the synchroniser
    task automatic hush();
        @(posedge pclk);
        gen_reset <= 1'b1;
        repeat (6) @(posedge pclk);
        gen_reset <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
endmodule

// ### tb/tb.sv
// tb: self-checking bench for the transceiver control block
// assumes dttc_host stands in for the processor on the dialling side
`timescale 1ns/1ns
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h830E;
    logic pready, pslverr, err, tone_present_in = 1'b0, output_enable_n = 1'b1;
    logic [3:0] tone_code_in = 4'h0, rx_code, rx_code_oe, rx_bus, tx_code, c;
    logic digit_valid, tone_load_strobe, gen_reset, tone_active, cadence_detect_out, irq;
    logic progress_line_in = 1'b0;
    logic [1:0] tone_out;
    int fail_count = 0, n_tests = 0;
    // 10 MHz clock
    initial forever #50 pclk = ~pclk;
    dttc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tone_present_in(tone_present_in), .tone_code_in(tone_code_in), .output_enable_n(output_enable_n),
        .rx_code(rx_code), .rx_code_oe(rx_code_oe), .digit_valid(digit_valid), .tx_code(tx_code),
        .tone_load_strobe(tone_load_strobe), .gen_reset(gen_reset), .tone_out(tone_out),
        .tone_active(tone_active), .progress_line_in(progress_line_in),
        .cadence_detect_out(cadence_detect_out), .irq(irq));
    dttc_host host (.pclk(pclk), .rx_code(rx_code), .rx_code_oe(rx_code_oe), .rx_bus(rx_bus),
        .tx_code(tx_code), .tone_load_strobe(tone_load_strobe), .gen_reset(gen_reset));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // expected status word from the flags the rules predict
    function automatic logic [31:0] st_exp(input logic ta, input logic cad, input logic dv, input logic [3:0] k);
        return {24'h0, ta, cad, dv, 1'b0, k};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // expected group frequency of a code from the dialling matrix
    function automatic int tone_hz(input logic [3:0] k, input logic high);
        int r, col;
        r = (k == 4'h0 || k >= 4'hA) ? 3 : (int'(k) - 1) / 3;
        col = (int'(k) - 1) % 3;
        if (k >= 4'hD) r = int'(k) - 13;
        if (k == 4'h0 || k >= 4'hD) col = 3;
        else if (k >= 4'hA) col = (k == 4'hA) ? 1 : (k == 4'hB) ? 0 : 2;
        if (high) return col == 0 ? 1209 : col == 1 ? 1336 : col == 2 ? 1477 : 1633;
        return r == 0 ? 697 : r == 1 ? 770 : r == 2 ? 852 : 941;
    endfunction
    // rising edges of each tone bit over 40 ms; one edge of slack covers start phase and step rounding
    task automatic tone_chk(input logic [3:0] k);
        int nlo, nhi, elo, ehi;
        logic [1:0] prev;
        nlo = 0;
        nhi = 0;
        elo = tone_hz(k, 1'b0) * 40 / 1000;
        ehi = tone_hz(k, 1'b1) * 40 / 1000;
        prev = tone_out;
        repeat (40 * dttc_pkg::MS_TO_CYC) begin
            @(posedge pclk);
            nlo += (tone_out[0] && !prev[0]) ? 1 : 0;
            nhi += (tone_out[1] && !prev[1]) ? 1 : 0;
            prev = tone_out;
        end
        chk(32'((nlo == elo - 1 || nlo == elo + 1) ? elo : nlo), 32'(elo));
        chk(32'((nhi == ehi - 1 || nhi == ehi + 1) ? ehi : nhi), 32'(ehi));
    endtask
    // one apb transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ms(input int n);
        repeat (n * dttc_pkg::MS_TO_CYC) @(posedge pclk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog well past the roughly 220 ms the sequence needs
    initial begin
        #400_000_000;
        fail_count++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk({digit_valid, tone_active, cadence_detect_out, irq, pready}, 32'h1);
        apb(1'b0, dttc_pkg::REG_CTRL, 32'h0);
        chk(rd, dttc_pkg::CTRL_RESET);
        apb(1'b1, dttc_pkg::REG_CTRL, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // every code, odd ones with strobe and reset on one wire
        for (int i = 0; i < 16; i++) begin
            host.load(i[3:0], i[0]);
            chk(tone_active, 32'h1);
        end
        seed = xs(seed);
        host.load(seed[3:0], 1'b0);
        tone_chk(seed[3:0]);
        host.hush();
        ms(1);
        chk({tone_active, tone_out}, 32'h0);
        apb(1'b1, dttc_pkg::REG_INT_MASK, 32'h1 << dttc_pkg::IRQ_DIGIT);
        seed = xs(seed);
        c = seed[3:0];
        output_enable_n <= 1'b0;
        fork
            begin
                tone_code_in <= c;
                tone_present_in <= 1'b1;
                ms(15);
                tone_present_in <= 1'b0;
                ms(40);
                chk(digit_valid, 32'h0);
                tone_present_in <= 1'b1;
                ms(45);
                chk({digit_valid, rx_code, rx_bus, rx_code_oe}, {19'h0, 1'b1, c, c, 4'hF});
                chk(irq, 32'h1);
                apb(1'b0, dttc_pkg::REG_STATUS, 32'h0);
                chk(rd, st_exp(1'b0, 1'b1, 1'b1, c));
                tone_present_in <= 1'b0;
                ms(15);
                chk(digit_valid, 32'h1);
                tone_present_in <= 1'b1;
                ms(20);
                tone_present_in <= 1'b0;
                ms(45);
                chk({digit_valid, rx_code}, 32'h0);
                apb(1'b1, dttc_pkg::REG_INT_STAT, 32'h1);
                @(posedge pclk);
                chk(irq, 32'h0);
                output_enable_n <= 1'b1;
                repeat (8) @(posedge pclk);
                chk(rx_code_oe, 32'h0);
            end
            begin
                progress_line_in <= 1'b1;
                ms(8);
                progress_line_in <= 1'b0;
                ms(45);
                chk(cadence_detect_out, 32'h0);
                progress_line_in <= 1'b1;
                ms(45);
                chk(cadence_detect_out, 32'h1);
                progress_line_in <= 1'b0;
                ms(15);
                chk(cadence_detect_out, 32'h1);
                progress_line_in <= 1'b1;
                ms(5);
                progress_line_in <= 1'b0;
                ms(45);
                chk(cadence_detect_out, 32'h0);
            end
        join
        // progress events are latched but masked, so the line stays low
        apb(1'b0, dttc_pkg::REG_INT_STAT, 32'h0);
        chk({irq, rd[2:0]}, 32'h6);
        close_out();
    end
endmodule
